/* File: design/hcd_params.svh */
// Constants of the haptic clamp and drive-time register bank.
// Assumes a 25 MHz core clock; included by bare name.
`ifndef HCD_PARAMS_SVH
`define HCD_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets on the host control interface
// ---------------------------------------------------------------
`define HCD_ADDR_STEADY   8'h24
`define HCD_ADDR_LOW_ONE  8'h25
`define HCD_ADDR_LOW_TWO  8'h26
`define HCD_ADDR_TIMING   8'h27

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define HCD_RST_STEADY    8'h64
`define HCD_RST_LOW_ONE   8'h80
`define HCD_RST_LOW_TWO   8'h00
`define HCD_RST_TIMING    8'h10
`define HCD_RD_UNMAPPED   8'h00

// ---------------------------------------------------------------
// Field positions in the timing register
// ---------------------------------------------------------------
`define HCD_MINF_BIT      7
`define HCD_RESYNC_BIT    6
`define HCD_RSVD_BIT      5
`define HCD_DT_MSB        4
`define HCD_DT_LSB        0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define HCD_CLK_HZ        25000000
`define HCD_LRA_BASE_US   500
`define HCD_LRA_STEP_US   100
`define HCD_ERM_BASE_US   1000
`define HCD_ERM_STEP_US   200
`define HCD_MINF_HI_HZ    125
`define HCD_MINF_LO_HZ    45
`define HCD_RESYNC_SHIFT  2
`define HCD_US_TO_CYC(us) (((us) * `HCD_CLK_HZ) / 1000000)

`endif

/* File: design/hcd_pkg.sv */
// Types shared by the haptic clamp and drive-time register bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package hcd_pkg;

	// Battery extension level, one-hot
	typedef enum logic [2:0] {
		HCD_BAT_NONE = 3'b001,
		HCD_BAT_ONE  = 3'b010,
		HCD_BAT_TWO  = 3'b100
	} hcd_batt_t;

	// Layout of the timing register
	typedef struct packed {
		logic       min_frequency_select;
		logic       resync_timing_method;
		logic       rsvd;
		logic [4:0] drive_time;
	} hcd_timing_t;

	typedef struct packed {
		logic [7:0]  steady_voltage_limit;
		logic [7:0]  low_battery_limit_one;
		logic [7:0]  low_battery_limit_two;
		hcd_timing_t timing;
	} hcd_cfg_t;

	// Status from the drive engine
	typedef struct packed {
		logic [7:0] overdrive_limit;
		logic       overdrive_phase;
		logic       calib_busy;
		logic       diag_busy;
		logic       resonant_mode;
		logic       back_emf_valid;
	} hcd_engine_t;

endpackage

`default_nettype wire

/* File: design/hcd_clamp_sel.sv */
// Active output voltage limit selection.
// Assumes all inputs come from logic on the same clock.
`default_nettype none
`include "hcd_params.svh"

module hcd_clamp_sel (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Configuration and engine state
	input  wire hcd_pkg::hcd_cfg_t    cfg,
	input  wire hcd_pkg::hcd_engine_t eng,
	input  wire hcd_pkg::hcd_batt_t   battery_extension_level,
	// Result
	output logic [7:0]            active_limit_r
);
	import hcd_pkg::*;

	wire       bat_ignored = eng.calib_busy | eng.diag_busy;
	wire       use_two     = (battery_extension_level == HCD_BAT_TWO) & ~bat_ignored;
	wire       use_one     = (battery_extension_level == HCD_BAT_ONE) & ~bat_ignored;
	wire [7:0] od_sub      = use_two ? cfg.low_battery_limit_two :
	                         use_one ? cfg.low_battery_limit_one :
	                                   eng.overdrive_limit;
	// Lower of rated and substituted clamp
	wire [7:0] steady_min  = (od_sub < cfg.steady_voltage_limit) ?
	                         od_sub : cfg.steady_voltage_limit;
	// Rated clamp does not restrict the overdrive section itself
	wire [7:0] limit_nxt   = eng.overdrive_phase ? od_sub : steady_min;

	always_ff @(posedge clk) begin
		if (!resetn)
			active_limit_r <= `HCD_RST_STEADY;
		else
			active_limit_r <= limit_nxt;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	steady_not_above_a: assert property (
		!eng.overdrive_phase |=> active_limit_r <= $past(cfg.steady_voltage_limit))
		else $error("steady limit exceeds rated clamp");

	level_two_wins_a: assert property (
		(use_two && !eng.overdrive_phase &&
		 cfg.low_battery_limit_two < cfg.steady_voltage_limit)
		|=> active_limit_r == $past(cfg.low_battery_limit_two))
		else $error("level two clamp not applied");

	level_one_used_a: assert property (
		(use_one && eng.overdrive_phase) |=> active_limit_r == $past(cfg.low_battery_limit_one))
		else $error("level one clamp not substituted");

	calib_ignores_bat_a: assert property (
		(bat_ignored && eng.overdrive_phase)
		|=> active_limit_r == $past(eng.overdrive_limit))
		else $error("battery clamp used during calibration");

endmodule

`default_nettype wire

/* File: design/hcd_drive_timer.sv */
// Drive time, re-sync window and drive tick generation.
// Assumes the tracked half period comes from the same clock domain.
`default_nettype none
`include "hcd_params.svh"

module hcd_drive_timer #(
	parameter int CNT_W        = 20,
	parameter int LRA_BASE_CYC = `HCD_US_TO_CYC(`HCD_LRA_BASE_US),
	parameter int LRA_STEP_CYC = `HCD_US_TO_CYC(`HCD_LRA_STEP_US),
	parameter int ERM_BASE_CYC = `HCD_US_TO_CYC(`HCD_ERM_BASE_US),
	parameter int ERM_STEP_CYC = `HCD_US_TO_CYC(`HCD_ERM_STEP_US),
	parameter int MINF_HI_CYC  = `HCD_CLK_HZ / `HCD_MINF_HI_HZ,
	parameter int MINF_LO_CYC  = `HCD_CLK_HZ / `HCD_MINF_LO_HZ
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// Configuration
	input  wire hcd_pkg::hcd_timing_t timing,
	input  wire logic               resonant_mode,
	input  wire logic               back_emf_valid,
	// Tracked drive time from the loop
	input  wire logic               track_valid,
	input  wire logic [CNT_W-1:0]   track_cycles,
	// Results
	output logic [CNT_W-1:0]        drive_cycles_r,
	output logic [CNT_W-1:0]        resync_cycles_r,
	output logic                    drive_tick_r
);
	import hcd_pkg::*;

	wire [CNT_W-1:0] code      = CNT_W'(timing.drive_time);
	wire [CNT_W-1:0] lra_cyc   = CNT_W'(LRA_BASE_CYC) + code * CNT_W'(LRA_STEP_CYC);
	wire [CNT_W-1:0] erm_cyc   = CNT_W'(ERM_BASE_CYC) + code * CNT_W'(ERM_STEP_CYC);
	// In resonant mode the field is only a seed; tracking takes over once back-EMF and a nonzero tracked count are valid
	wire             tracking  = resonant_mode & back_emf_valid & track_valid &
	                             (track_cycles != '0);
	wire [CNT_W-1:0] dt_nxt    = !resonant_mode ? erm_cyc :
	                             tracking       ? track_cycles : lra_cyc;
	wire [CNT_W-1:0] minf_cyc  = timing.min_frequency_select ?
	                             CNT_W'(MINF_LO_CYC) : CNT_W'(MINF_HI_CYC);
	wire [CNT_W-1:0] scaled    = drive_cycles_r + (drive_cycles_r >> `HCD_RESYNC_SHIFT);
	wire [CNT_W-1:0] rs_nxt    = timing.resync_timing_method ? scaled : minf_cyc;
	logic [CNT_W-1:0] tick_cnt_r;
	wire             tick_end  = (tick_cnt_r >= drive_cycles_r - CNT_W'(1));

	always_ff @(posedge clk) begin
		if (!resetn) begin
			drive_cycles_r  <= CNT_W'(LRA_BASE_CYC);
			resync_cycles_r <= CNT_W'(MINF_HI_CYC);
			tick_cnt_r      <= '0;
			drive_tick_r    <= 1'b0;
		end else begin
			drive_cycles_r  <= dt_nxt;
			resync_cycles_r <= rs_nxt;
			tick_cnt_r      <= tick_end ? '0 : tick_cnt_r + CNT_W'(1);
			drive_tick_r    <= tick_end;
		end
	end

	generate
		if (CNT_W < 20 || CNT_W > 31)
			$error("hcd_drive_timer: CNT_W must be 20..31 to hold the longest period");
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	erm_period_a: assert property (
		!resonant_mode |=> drive_cycles_r == $past(erm_cyc))
		else $error("eccentric sample period wrong");

	free_run_a: assert property (
		(resonant_mode && !back_emf_valid) |=> drive_cycles_r == $past(lra_cyc))
		else $error("free-run drive time wrong");

	minf_window_a: assert property (
		(!timing.resync_timing_method && timing.min_frequency_select) [*2]
		|=> resync_cycles_r == CNT_W'(MINF_LO_CYC))
		else $error("minimum frequency window wrong");

	resync_scaled_a: assert property (
		timing.resync_timing_method |=>
		resync_cycles_r == $past(drive_cycles_r) + ($past(drive_cycles_r) >> 2))
		else $error("resync window not 1.25 times drive time");

endmodule

`default_nettype wire

/* File: design/hcd_clamp_drive_regs.sv */
// Haptic driver clamp and drive-time configuration registers.
// Assumes a host control interface slave that turns bus cycles into
// single-cycle register write strobes and a registered read path,
// and a drive engine and battery monitor on the same clock.
`default_nettype none
`include "hcd_params.svh"

module hcd_clamp_drive_regs #(
	parameter int CNT_W        = 20,
	parameter int LRA_BASE_CYC = `HCD_US_TO_CYC(`HCD_LRA_BASE_US),
	parameter int LRA_STEP_CYC = `HCD_US_TO_CYC(`HCD_LRA_STEP_US),
	parameter int ERM_BASE_CYC = `HCD_US_TO_CYC(`HCD_ERM_BASE_US),
	parameter int ERM_STEP_CYC = `HCD_US_TO_CYC(`HCD_ERM_STEP_US),
	parameter int MINF_HI_CYC  = `HCD_CLK_HZ / `HCD_MINF_HI_HZ,
	parameter int MINF_LO_CYC  = `HCD_CLK_HZ / `HCD_MINF_LO_HZ
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  resetn,
	// Register port of the host control interface
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	output logic [7:0]                 reg_rdata_r,
	// Drive engine and battery monitor state
	input  wire hcd_pkg::hcd_engine_t  eng,
	input  wire hcd_pkg::hcd_batt_t    battery_extension_level,
	input  wire logic                  track_valid,
	input  wire logic [CNT_W-1:0]      track_cycles,
	// To the closed-loop drive engine
	output logic [7:0]                 active_limit_r,
	output logic                       min_frequency_select_r,
	output logic [CNT_W-1:0]           drive_cycles_r,
	output logic [CNT_W-1:0]           resync_cycles_r,
	output logic                       drive_tick_r
);
	import hcd_pkg::*;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	wire hit_steady  = (reg_addr == `HCD_ADDR_STEADY);
	wire hit_low_one = (reg_addr == `HCD_ADDR_LOW_ONE);
	wire hit_low_two = (reg_addr == `HCD_ADDR_LOW_TWO);
	wire hit_timing  = (reg_addr == `HCD_ADDR_TIMING);
	wire hit_any     = hit_steady | hit_low_one | hit_low_two | hit_timing;

	wire wr_steady   = reg_wr & hit_steady;
	wire wr_low_one  = reg_wr & hit_low_one;
	wire wr_low_two  = reg_wr & hit_low_two;
	wire wr_timing   = reg_wr & hit_timing;

	// ---------------------------------------------------------------
	// Register storage
	// ---------------------------------------------------------------
	logic [7:0]  steady_r;
	logic [7:0]  low_one_r;
	logic [7:0]  low_two_r;
	hcd_timing_t timing_r;

	wire [7:0]   steady_nxt  = wr_steady  ? reg_wdata : steady_r;
	wire [7:0]   low_one_nxt = wr_low_one ? reg_wdata : low_one_r;
	wire [7:0]   low_two_nxt = wr_low_two ? reg_wdata : low_two_r;
	// Reserved bit is writable and reads back what was written
	wire hcd_timing_t timing_nxt = wr_timing ? hcd_timing_t'(reg_wdata) : timing_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			steady_r  <= `HCD_RST_STEADY;
			low_one_r <= `HCD_RST_LOW_ONE;
			low_two_r <= `HCD_RST_LOW_TWO;
			timing_r  <= hcd_timing_t'(`HCD_RST_TIMING);
		end else begin
			steady_r  <= steady_nxt;
			low_one_r <= low_one_nxt;
			low_two_r <= low_two_nxt;
			timing_r  <= timing_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Unmapped offsets read as zero so a stray poll never aliases a register
	wire [7:0] rd_mux = hit_steady  ? steady_r  :
	                    hit_low_one ? low_one_r :
	                    hit_low_two ? low_two_r :
	                    hit_timing  ? 8'(timing_r) : `HCD_RD_UNMAPPED;

	always_ff @(posedge clk) begin
		if (!resetn)
			reg_rdata_r <= `HCD_RD_UNMAPPED;
		else
			reg_rdata_r <= rd_mux;
	end

	// ---------------------------------------------------------------
	// Configuration carried to the engine
	// ---------------------------------------------------------------
	hcd_cfg_t cfg;
	assign cfg.steady_voltage_limit  = steady_r;
	assign cfg.low_battery_limit_one = low_one_r;
	assign cfg.low_battery_limit_two = low_two_r;
	assign cfg.timing                = timing_r;

	always_ff @(posedge clk) begin
		if (!resetn)
			min_frequency_select_r <= 1'(`HCD_RST_TIMING >> `HCD_MINF_BIT);
		else
			min_frequency_select_r <= timing_r.min_frequency_select;
	end

	// ---------------------------------------------------------------
	// Clamp selection
	// ---------------------------------------------------------------
	hcd_clamp_sel u_clamp (
		.clk                     (clk),
		.resetn                  (resetn),
		.cfg                     (cfg),
		.eng                     (eng),
		.battery_extension_level (battery_extension_level),
		.active_limit_r          (active_limit_r)
	);

	// ---------------------------------------------------------------
	// Drive time and re-sync timing
	// ---------------------------------------------------------------
	// Host is expected to seed drive time near half the actuator period;
	// a poor seed only slows lock, tracking corrects it.
	hcd_drive_timer #(
		.CNT_W        (CNT_W),
		.LRA_BASE_CYC (LRA_BASE_CYC),
		.LRA_STEP_CYC (LRA_STEP_CYC),
		.ERM_BASE_CYC (ERM_BASE_CYC),
		.ERM_STEP_CYC (ERM_STEP_CYC),
		.MINF_HI_CYC  (MINF_HI_CYC),
		.MINF_LO_CYC  (MINF_LO_CYC)
	) u_timer (
		.clk             (clk),
		.resetn          (resetn),
		.timing          (timing_r),
		.resonant_mode   (eng.resonant_mode),
		.back_emf_valid  (eng.back_emf_valid),
		.track_valid     (track_valid),
		.track_cycles    (track_cycles),
		.drive_cycles_r  (drive_cycles_r),
		.resync_cycles_r (resync_cycles_r),
		.drive_tick_r    (drive_tick_r)
	);

	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	generate
		if (LRA_BASE_CYC < 1 || ERM_BASE_CYC < 1 || MINF_HI_CYC < 1)
			$error("hcd_clamp_drive_regs: timing counts must be at least one cycle");
		if (MINF_LO_CYC >= (1 << CNT_W))
			$error("hcd_clamp_drive_regs: CNT_W too narrow for the 45 Hz window");
	endgenerate

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	reg_write_a: assert property (
		(reg_wr && hit_steady) ##1 hit_steady |=> reg_rdata_r == $past(reg_wdata, 2))
		else $error("steady limit write not read back");

	low_one_write_a: assert property (
		(reg_wr && hit_low_one) ##1 hit_low_one |=> reg_rdata_r == $past(reg_wdata, 2))
		else $error("level one clamp write not read back");

	low_two_write_a: assert property (
		(reg_wr && hit_low_two) ##1 hit_low_two |=> reg_rdata_r == $past(reg_wdata, 2))
		else $error("level two clamp write not read back");

	timing_write_a: assert property (
		(reg_wr && hit_timing) ##1 hit_timing |=> reg_rdata_r == $past(reg_wdata, 2))
		else $error("timing register write not read back");

	// Stray writes must leave every register untouched
	unmapped_write_a: assert property (
		(reg_wr && !hit_any) |=> $stable(steady_r) && $stable(low_one_r) &&
		$stable(low_two_r) && $stable(timing_r))
		else $error("unmapped write changed a register");

	unmapped_read_a: assert property (
		!hit_any |=> reg_rdata_r == `HCD_RD_UNMAPPED)
		else $error("unmapped offset read nonzero");

	steady_clamp_a: assert property (
		(!eng.overdrive_phase && !reg_wr) [*2] |=>
		active_limit_r <= steady_r)
		else $error("steady limit above rated clamp");

	od_lower_a: assert property (
		(battery_extension_level == HCD_BAT_NONE && !eng.overdrive_phase &&
		 eng.overdrive_limit < steady_r && !reg_wr)
		|=> active_limit_r == $past(eng.overdrive_limit))
		else $error("lower overdrive clamp not applied");

	bat_lower_a: assert property (
		(battery_extension_level == HCD_BAT_ONE && !eng.calib_busy && !eng.diag_busy &&
		 !eng.overdrive_phase && low_one_r < steady_r && !reg_wr)
		|=> active_limit_r == $past(low_one_r))
		else $error("lower battery clamp not applied");

	bat_change_a: assert property (
		($changed(battery_extension_level) && battery_extension_level == HCD_BAT_TWO &&
		 !eng.calib_busy && !eng.diag_busy && !eng.overdrive_phase)
		|=> active_limit_r <= $past(low_two_r))
		else $error("limit not re-evaluated on battery change");

	level_two_sub_a: assert property (
		(battery_extension_level == HCD_BAT_TWO && !eng.calib_busy && !eng.diag_busy &&
		 eng.overdrive_phase)
		|=> active_limit_r == $past(low_two_r))
		else $error("level two clamp not substituted");

	calib_no_sub_a: assert property (
		(eng.calib_busy && eng.overdrive_phase)
		|=> active_limit_r == $past(eng.overdrive_limit))
		else $error("battery clamp used during calibration");

	erm_seed_a: assert property (
		(!eng.resonant_mode && timing_r.drive_time == 5'd11) [*2]
		|=> drive_cycles_r == CNT_W'(ERM_BASE_CYC + 11 * ERM_STEP_CYC))
		else $error("eccentric code 11 sample period wrong");

	resync_minf_a: assert property (
		(!timing_r.resync_timing_method && !timing_r.min_frequency_select)
		|=> resync_cycles_r == CNT_W'(MINF_HI_CYC))
		else $error("resync window not the 125 Hz window");

	lra_seed_a: assert property (
		(eng.resonant_mode && !eng.back_emf_valid && timing_r.drive_time == 5'd11) [*2]
		|=> drive_cycles_r == CNT_W'(LRA_BASE_CYC + 11 * LRA_STEP_CYC))
		else $error("resonant code 11 drive time wrong");

	tracking_a: assert property (
		(eng.resonant_mode && eng.back_emf_valid && track_valid && track_cycles != '0)
		|=> drive_cycles_r == $past(track_cycles))
		else $error("tracked drive time not adopted");

	minf_out_a: assert property (
		wr_timing |=> ##1 min_frequency_select_r == $past(reg_wdata[`HCD_MINF_BIT], 2))
		else $error("minimum frequency select not forwarded");

endmodule

`default_nettype wire

/* File: verification/hcd_host_model.sv */
// Host side of the register port: byte writes and address setup.
// Assumes its tasks are called by the testbench on the core clock.
`default_nettype none

module hcd_host_model (
	// Clock
	input  wire logic  clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic       reg_wr
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
	end

	// One strobe per write; data inverted once released, so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// Address held for the registered read path
	task automatic point(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
	endtask
endmodule

`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench of the clamp and drive-time register bank.
// Assumes shortened timing parameters; the host model drives the register port.
`default_nettype none
`include "hcd_params.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import hcd_pkg::*;

	localparam int LB = 50, LS = 10, EB = 100, ES = 20, MH = 400, ML = 1000;
	typedef struct {int sel; logic [19:0] v;} hcd_note_t;

	logic clk = 1'b0, resetn = 1'b0, chk = 1'b0, track_valid = 1'b0, tick;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata_r, active_limit_r;
	logic        reg_wr, minf;
	logic [19:0] track_cycles = 20'h0, drive_cycles_r, resync_cycles_r, gap, cnt = 20'h0;
	hcd_engine_t eng = '{8'hff, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	hcd_batt_t   batt = HCD_BAT_NONE;
	hcd_note_t   notes[$];
	hcd_note_t   n;
	int          err_total = 0, comparisons = 0;
	string       names[6] = '{"rdata", "limit", "minf", "drive", "resync", "tick_gap"};

	always #20 clk = ~clk;

	hcd_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr));

	hcd_clamp_drive_regs #(.CNT_W(20), .LRA_BASE_CYC(LB), .LRA_STEP_CYC(LS),
		.ERM_BASE_CYC(EB), .ERM_STEP_CYC(ES), .MINF_HI_CYC(MH), .MINF_LO_CYC(ML)) dut (
		.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rdata_r(reg_rdata_r), .eng(eng),
		.battery_extension_level(batt), .track_valid(track_valid),
		.track_cycles(track_cycles), .active_limit_r(active_limit_r),
		.min_frequency_select_r(minf), .drive_cycles_r(drive_cycles_r),
		.resync_cycles_r(resync_cycles_r), .drive_tick_r(tick));

	// Spacing between drive ticks, in cycles
	always @(posedge clk) begin
		cnt <= tick ? 20'h1 : cnt + 20'h1;
		if (tick)
			gap <= cnt;
	end

	// ---------------------------------------------------------------
	// Checking
	// ---------------------------------------------------------------
	task automatic check(input string nm, input logic [19:0] s, input logic [19:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, s);
		end
	endtask

	function automatic logic [19:0] seen(input int s);
		case (s)
			0: return {12'h0, reg_rdata_r};
			1: return {12'h0, active_limit_r};
			2: return {19'h0, minf};
			3: return drive_cycles_r;
			4: return resync_cycles_r;
			default: return gap;
		endcase
	endfunction

	always @(negedge clk) begin
		if (chk) begin
			while (notes.size() != 0) begin
				n = notes.pop_front();
				check(names[n.sel], seen(n.sel), n.v);
			end
		end
	end

	task automatic note(input int s, input logic [19:0] v);
		notes.push_back('{s, v});
	endtask

	task automatic sample;
		chk <= 1'b1;
		@(posedge clk);
		chk <= 1'b0;
	endtask

	function automatic logic [7:0] lim(input logic [7:0] r, od, l1, l2,
		input hcd_batt_t b, input logic ign, ph);
		logic [7:0] s;
		s = ign ? od : (b == HCD_BAT_TWO) ? l2 : (b == HCD_BAT_ONE) ? l1 : od;
		return ph ? s : ((s < r) ? s : r);
	endfunction

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge clk);
		err_total++;
		end_of_test;
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		logic [7:0]  r, o, a, b, k, adr[6], rst[6];
		logic [19:0] d;
		logic [4:0]  c;
		hcd_batt_t   bt;
		adr = '{`HCD_ADDR_STEADY, `HCD_ADDR_LOW_ONE, `HCD_ADDR_LOW_TWO, `HCD_ADDR_TIMING,
			8'h28, 8'h23};
		rst = '{8'h64, 8'h80, 8'h00, 8'h10, 8'h00, 8'h00};
		void'($urandom(29));
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			host.point(adr[i]);
			note(0, {12'h0, rst[i]});
			sample;
		end
		note(1, 20'h64);
		note(2, 20'h0);
		note(3, LB + 16 * LS);
		note(4, MH);
		sample;
		$display("test reset done");

		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			host.wr(adr[i], r);
			host.wr(8'h28, ~r);
			host.point(adr[i]);
			note(0, {12'h0, r});
			sample;
			host.point(8'h28);
			note(0, 20'h0);
			sample;
		end
		$display("test access done");

		for (int i = 0; i < 16; i++) begin
			r = $urandom;
			o = $urandom;
			a = $urandom;
			b = $urandom;
			k = $urandom;
			bt = (k[1:0] == 2'h0) ? HCD_BAT_NONE : k[0] ? HCD_BAT_ONE : HCD_BAT_TWO;
			host.wr(`HCD_ADDR_STEADY, r);
			host.wr(`HCD_ADDR_LOW_ONE, a);
			host.wr(`HCD_ADDR_LOW_TWO, b);
			@(posedge clk);
			batt <= bt;
			eng.overdrive_limit <= o;
			eng.overdrive_phase <= k[2] & k[5];
			eng.calib_busy <= k[3] & k[4];
			eng.diag_busy <= k[3] & ~k[4];
			repeat (3) @(posedge clk);
			note(1, {12'h0, lim(r, o, a, b, bt, k[3], k[2] & k[5])});
			sample;
		end
		$display("test clamp done");

		for (int i = 0; i < 16; i++) begin
			k = $urandom;
			c = (i < 2) ? 5'(i * 11) : 5'($urandom);
			r = {i[1], i[2], k[7], c};
			host.wr(`HCD_ADDR_TIMING, r);
			@(posedge clk);
			eng.resonant_mode <= i[3];
			eng.back_emf_valid <= k[0];
			track_valid <= k[1];
			track_cycles <= 20'd60 + 20'(k[6:2]);
			d = (i[3] & k[0] & k[1]) ? 20'd60 + 20'(k[6:2]) :
				i[3] ? LB + c * LS : EB + c * ES;
			repeat (3) @(posedge clk);
			host.point(`HCD_ADDR_TIMING);
			note(0, {12'h0, r});
			note(2, {19'h0, i[1]});
			note(3, d);
			note(4, i[2] ? d + (d >> 2) : i[1] ? ML : MH);
			sample;
		end
		$display("test timing done");

		// Code 11 as an eccentric sample period, then tracking takes over
		host.wr(`HCD_ADDR_TIMING, 8'h0b);
		@(posedge clk);
		eng.resonant_mode <= 1'b0;
		repeat (700) @(posedge clk);
		note(5, EB + 11 * ES);
		sample;
		eng.resonant_mode <= 1'b1;
		eng.back_emf_valid <= 1'b1;
		track_valid <= 1'b1;
		track_cycles <= 20'd37;
		repeat (120) @(posedge clk);
		note(5, 20'd37);
		sample;
		$display("test tick done");
		end_of_test;
	end
endmodule

`default_nettype wire
